/* hdl/acc_adc_ctrl.sv */
/*
 * Conversion controller for an eight-input 10-bit successive-approximation
 * cell: prescaler, triggers, sequencer, results, flags, compare window.
 * Assumes the analog cell answers on ref_clk_in (done and data synchronous),
 * while timer outputs and the trigger pin are asynchronous.
 */
`timescale 1ns/10ps
module acc_adc_ctrl (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	input wire logic [2:0] timer_waveform_output_in,
	input wire logic external_trigger_pin_in,
	input wire logic cell_done_in,
	input wire logic [9:0] cell_data_in,
	output logic cell_start_out,
	output logic [2:0] cell_channel_out,
	output logic cell_power_out,
	output logic cell_standby_out,
	output logic conversion_clock_tick_out,
	output logic dma_request_out,
	output logic irq_out
);
	// ****************************************
	// Helpers
	// ****************************************
	// Byte-lane merge for writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// First enabled slot at or after a start index; bit 3 says found
	function automatic logic [3:0] first_slot(input logic [7:0] mask, input logic [3:0] from);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 7; i >= 0; i--) begin
			if (mask[i] && (4'(i) >= from)) begin
				r = {1'b1, 3'(i)};
			end
		end
		return r;
	endfunction

	// Address falls in the eight-word channel result window
	function automatic logic is_res(input logic [7:0] a);
		return (a >= acc_pkg::OFS_CH_RESULT) && (a < 8'(acc_pkg::OFS_CH_RESULT + 8'h20));
	endfunction

	// Channel index of a result address, counted from the window base
	function automatic logic [2:0] res_idx(input logic [7:0] a);
		logic [7:0] r;
		r = 8'(a - acc_pkg::OFS_CH_RESULT);
		return r[4:2];
	endfunction

	// Channel held by a slot: own index or programmed order
	function automatic logic [2:0] slot_chan(input logic [31:0] seqr, input logic user_sequence_enable,
		input logic [2:0] s);
		return user_sequence_enable ? seqr[{s, 2'b00} +: 3] : s;
	endfunction

	// Window test; mode 0 below, 1 above, 2 inside, 3 outside
	function automatic logic cmp_hit(input logic [9:0] d, input logic [9:0] lo,
		input logic [9:0] hi, input logic [1:0] m);
		logic r;
		case (m)
			2'd0: r = d < lo;
			2'd1: r = d > hi;
			2'd2: r = (d >= lo) && (d <= hi);
			default: r = (d < lo) || (d > hi);
		endcase
		return r;
	endfunction

	// ****************************************
	// State
	// ****************************************
	acc_pkg::acc_state_t st; // Registered state
	acc_pkg::acc_state_t next_st; // Its next value
	logic take; // Bus request accepted now
	logic rd_side; // Read accepted now
	logic [31:0] rd; // Read mux
	logic [8:0] period; // Divider reload
	logic [3:0] trg_src; // Synchronised sources
	logic trg_sel; // Selected source level
	logic trig; // Sequence request this cycle
	logic [3:0] nxt; // Next slot search
	logic [7:0] seq_mask; // Slots taking part
	logic [9:0] res; // Resolution-adjusted result
	logic [9:0] lo; // Scaled low threshold
	logic [9:0] hi; // Scaled high threshold
	logic [2:0] ch; // Channel completing
	logic [1:0] filt_lim; // Matches needed minus one
	logic [7:0] startup_ticks; // Wake wait
	logic [31:0] flags; // Status layout

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb begin
		next_st = st;
		rd = 32'h0000_0000;
		next_st.cell_start = 1'b0;
		next_st.dma = 1'b0;
		// Bus: one request, one registered ack
		take = wb_cyc_in && wb_stb_in && !st.ack;
		rd_side = take && !wb_we_in;
		next_st.ack = take;
		flags = {5'h00, st.compare_event_flag, st.general_overrun_flag, st.data_ready_flag, 16'h0000, st.eoc};
		// Read mux and write decode
		case (wb_adr_in)
			acc_pkg::OFS_MODE: rd = st.mode;
			acc_pkg::OFS_SEQ_ORDER: rd = st.seqr;
			acc_pkg::OFS_CH_STATUS: rd = {24'h00_0000, st.chsr};
			acc_pkg::OFS_LAST_RESULT: begin
				rd = {17'h0_0000, st.lchan, 2'b00, st.ldata};
				if (rd_side) begin
					next_st.data_ready_flag = 1'b0;
				end
			end
			acc_pkg::OFS_INT_ENABLE: rd = st.ier;
			acc_pkg::OFS_INT_STATUS: begin
				rd = flags;
				if (rd_side) begin
					next_st.general_overrun_flag = 1'b0;
					next_st.compare_event_flag = 1'b0;
					next_st.filt = 2'b00;
				end
			end
			acc_pkg::OFS_OVERRUN: begin
				rd = {24'h00_0000, st.channel_overrun_flag};
				if (rd_side) begin
					next_st.channel_overrun_flag = 8'h00;
				end
			end
			acc_pkg::OFS_EXT_MODE: rd = st.emr;
			acc_pkg::OFS_CMP_WINDOW: rd = st.cwr;
			default: begin
				// Eight channel results; anything else reads zero
				if (is_res(wb_adr_in)) begin
					rd = {22'h00_0000, st.cdr[res_idx(wb_adr_in)]};
				end
			end
		endcase
		// Result read clears its end flag
		if (rd_side && is_res(wb_adr_in)) begin
			next_st.eoc[res_idx(wb_adr_in)] = 1'b0;
		end
		if (take) begin
			next_st.rdata = wb_we_in ? 32'h0000_0000 : rd;
		end
		if (take && wb_we_in) begin
			case (wb_adr_in)
				acc_pkg::OFS_MODE: next_st.mode = merge(st.mode, wb_dat_in, wb_sel_in);
				acc_pkg::OFS_SEQ_ORDER: next_st.seqr = merge(st.seqr, wb_dat_in, wb_sel_in);
				acc_pkg::OFS_CH_ENABLE: begin
					if (wb_sel_in[0]) begin
						next_st.chsr = st.chsr | wb_dat_in[7:0];
					end
				end
				acc_pkg::OFS_CH_DISABLE: begin
					if (wb_sel_in[0]) begin
						next_st.chsr = st.chsr & ~wb_dat_in[7:0];
					end
				end
				acc_pkg::OFS_INT_ENABLE: next_st.ier = merge(st.ier, wb_dat_in, wb_sel_in);
				acc_pkg::OFS_EXT_MODE: next_st.emr = merge(st.emr, wb_dat_in, wb_sel_in);
				acc_pkg::OFS_CMP_WINDOW: next_st.cwr = merge(st.cwr, wb_dat_in, wb_sel_in);
				default: ;
			endcase
		end
		// Prescaler: undivided, by three, or 2*(field+1)
		if (st.mode[acc_pkg::MR_UNDIVIDED]) begin
			period = 9'h000;
		end else if (st.mode[acc_pkg::MR_DIV_BY_THREE]) begin
			period = acc_pkg::DIVIDE_BY_THREE_SELECT_PERIOD;
		end else begin
			period = {st.mode[acc_pkg::MR_DIVIDER_LSB +: 8], 1'b1};
		end
		next_st.tick = (st.div_cnt >= period);
		next_st.div_cnt = next_st.tick ? 9'h000 : 9'(st.div_cnt + 9'h001);
		// Trigger pins: two flops, then edge on the second
		next_st.sync1 = {external_trigger_pin_in, timer_waveform_output_in};
		next_st.sync2 = st.sync1;
		trg_src = st.sync2;
		trg_sel = trg_src[st.mode[acc_pkg::MR_TRG_SEL_LSB +: 2]];
		next_st.trg_prev = trg_sel;
		trig = st.mode[acc_pkg::MR_TRG_ENABLE] ? (trg_sel && !st.trg_prev) : 1'b0;
		if (take && wb_we_in && wb_adr_in == acc_pkg::OFS_CONTROL && wb_sel_in[0]
			&& wb_dat_in[acc_pkg::CR_START]) begin
			trig = 1'b1;
		end
		// Slot set: every slot gated by its enable bit
		seq_mask = st.chsr;
		nxt = first_slot(seq_mask, {1'b0, st.slot} + 4'h1);
		startup_ticks = 8'(st.mode[acc_pkg::MR_STARTUP_LSB +: 4] * acc_pkg::STARTUP_STEP);
		// Result shaping and compare thresholds
		ch = st.cur_ch;
		res = st.mode[acc_pkg::MR_LOW_RES] ? {2'b00, cell_data_in[9:2]} : cell_data_in;
		lo = st.cwr[9:0];
		hi = st.cwr[acc_pkg::CWR_HIGH_LSB +: 10];
		if (st.mode[acc_pkg::MR_LOW_RES]) begin
			lo = {2'b00, lo[9:2]};
			hi = {2'b00, hi[9:2]};
		end
		filt_lim = st.emr[acc_pkg::EMR_FILTER_LSB +: 2];
		// Sequencer
		case (st.fsm)
			acc_pkg::S_IDLE: begin
				// Requests while busy are simply not seen here
				if (trig && first_slot(seq_mask, 4'h0) != 4'h0) begin
					next_st.slot = first_slot(seq_mask, 4'h0)[2:0];
					next_st.tmr = 8'h00;
					next_st.fsm = st.mode[acc_pkg::MR_SLEEP] ? acc_pkg::S_WAKE : acc_pkg::S_TRACK;
				end
			end
			acc_pkg::S_WAKE: begin
				if (st.tmr >= startup_ticks) begin
					next_st.tmr = 8'h00;
					next_st.fsm = acc_pkg::S_TRACK;
				end else if (st.tick) begin
					next_st.tmr = 8'(st.tmr + 8'h01);
				end
			end
			acc_pkg::S_TRACK: begin
				if (st.tmr >= {4'h0, st.mode[acc_pkg::MR_TRACK_LSB +: 4]}) begin
					next_st.cell_start = 1'b1;
					next_st.cur_ch = slot_chan(st.seqr, st.mode[acc_pkg::MR_USER_SEQ], st.slot);
					next_st.tmr = 8'h00;
					next_st.fsm = acc_pkg::S_CONV;
				end else if (st.tick) begin
					next_st.tmr = 8'(st.tmr + 8'h01);
				end
			end
			acc_pkg::S_CONV: begin
				// Next channel already tracking; long tracking carries on after
				if (st.tick && st.tmr != 8'hFF) begin
					next_st.tmr = 8'(st.tmr + 8'h01);
				end
				if (cell_done_in) begin
					next_st.cdr[ch] = res;
					next_st.ldata = res;
					next_st.lchan = st.emr[acc_pkg::EMR_TAG] ? ch : 3'h0;
					next_st.eoc[ch] = 1'b1;
					next_st.data_ready_flag = 1'b1;
					// Asks for a transfer when ready was clear, or when the shared result is read in this same cycle
					next_st.dma = !st.data_ready_flag
						|| (rd_side && wb_adr_in == acc_pkg::OFS_LAST_RESULT);
					if (st.eoc[ch]) begin
						next_st.channel_overrun_flag[ch] = 1'b1;
					end
					if (st.data_ready_flag) begin
						next_st.general_overrun_flag = 1'b1;
					end
					if ((st.emr[acc_pkg::EMR_CMP_ALL]
						|| ch == st.emr[acc_pkg::EMR_CMP_SEL_LSB +: 3])) begin
						if (cmp_hit(res, lo, hi, st.emr[1:0])) begin
							if (next_st.filt >= filt_lim) begin
								next_st.compare_event_flag = 1'b1;
								next_st.filt = 2'b00;
							end else begin
								next_st.filt = 2'(next_st.filt + 2'b01);
							end
						end else begin
							next_st.filt = 2'b00;
						end
					end
					if (nxt[3]) begin
						next_st.slot = nxt[2:0];
						next_st.fsm = acc_pkg::S_TRACK;
					end else begin
						next_st.fsm = acc_pkg::S_IDLE;
					end
				end
			end
			default: next_st.fsm = acc_pkg::S_IDLE;
		endcase
		// Cell power: off in sleep when idle, partial with fast wakeup
		next_st.pwr = !st.mode[acc_pkg::MR_SLEEP] || next_st.fsm != acc_pkg::S_IDLE;
		next_st.stby = !next_st.pwr && st.mode[acc_pkg::MR_FAST_WAKE];
		next_st.irq = |({5'h00, next_st.compare_event_flag, next_st.general_overrun_flag, next_st.data_ready_flag, 16'h0000,
			next_st.eoc} & st.ier);
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			st <= '0;
			st.mode <= acc_pkg::MODE_RST;
			st.seqr <= acc_pkg::SEQ_RST;
			st.pwr <= 1'b1;
			st.fsm <= acc_pkg::S_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// ****************************************
	// Outputs from flops; the cell channel is muxed from slot and order
	// ****************************************
	assign wb_dat_out = st.rdata;
	assign wb_ack_out = st.ack;
	assign cell_start_out = st.cell_start;
	assign cell_channel_out = slot_chan(st.seqr, st.mode[acc_pkg::MR_USER_SEQ], st.slot);
	assign cell_power_out = st.pwr;
	assign cell_standby_out = st.stby;
	assign conversion_clock_tick_out = st.tick;
	assign dma_request_out = st.dma;
	assign irq_out = st.irq;
endmodule // acc_adc_ctrl

/* hdl/acc_pkg.sv */
/*
 * Constants and types for the conversion controller: register offsets,
 * field positions, reset values, timing steps and the sequencer states.
 * Assumes a Wishbone byte address of eight bits, one 32-bit word per register.
 */
package acc_pkg;
	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [7:0] OFS_CONTROL = 8'h00; // Start command, write only
	localparam logic [7:0] OFS_MODE = 8'h04; // Mode register
	localparam logic [7:0] OFS_SEQ_ORDER = 8'h08; // Eight slot channels
	localparam logic [7:0] OFS_CH_ENABLE = 8'h10; // Write one to enable
	localparam logic [7:0] OFS_CH_DISABLE = 8'h14; // Write one to disable
	localparam logic [7:0] OFS_CH_STATUS = 8'h18; // Enabled channel set
	localparam logic [7:0] OFS_LAST_RESULT = 8'h20; // Shared result
	localparam logic [7:0] OFS_INT_ENABLE = 8'h24; // Interrupt enables
	localparam logic [7:0] OFS_INT_STATUS = 8'h30; // Flags, clears overrun
	localparam logic [7:0] OFS_OVERRUN = 8'h3C; // Channel overruns
	localparam logic [7:0] OFS_EXT_MODE = 8'h40; // Compare and tag
	localparam logic [7:0] OFS_CMP_WINDOW = 8'h44; // Thresholds
	localparam logic [7:0] OFS_CH_RESULT = 8'h50; // First of eight results
	// ****************************************
	// Field positions
	// ****************************************
	localparam int CR_START = 1;
	localparam int MR_TRG_ENABLE = 0;
	localparam int MR_TRG_SEL_LSB = 1; // Two bits
	localparam int MR_LOW_RES = 4;
	localparam int MR_SLEEP = 5;
	localparam int MR_FAST_WAKE = 6;
	localparam int MR_UNDIVIDED = 7;
	localparam int MR_DIVIDER_LSB = 8; // Eight bits
	localparam int MR_STARTUP_LSB = 16; // Four bits
	localparam int MR_DIV_BY_THREE = 20;
	localparam int MR_TRACK_LSB = 24; // Four bits
	localparam int MR_USER_SEQ = 31;
	localparam int EMR_CMP_SEL_LSB = 4; // Three bits
	localparam int EMR_CMP_ALL = 9;
	localparam int EMR_FILTER_LSB = 12; // Two bits
	localparam int EMR_TAG = 24;
	localparam int CWR_HIGH_LSB = 16; // Ten bits each
	localparam int ISR_DATA_READY = 24;
	localparam int ISR_GEN_OVERRUN = 25;
	localparam int ISR_CMP_EVENT = 26;
	localparam int LCDR_CHAN_LSB = 12; // Three bits
	// ****************************************
	// Reset values and timing
	// ****************************************
	localparam logic [31:0] MODE_RST = 32'h0000_0000; // Full resolution, no trigger
	localparam logic [31:0] SEQ_RST = 32'h7654_3210; // Identity order
	localparam logic [7:0] STARTUP_STEP = 8'h08; // Ticks per startup unit
	localparam logic [8:0] DIVIDE_BY_THREE_SELECT_PERIOD = 9'h002; // Three cycles minus one
	// ****************************************
	// Sequencer states, one-hot
	// ****************************************
	typedef enum logic [3:0] {
		S_IDLE = 4'b0001,
		S_WAKE = 4'b0010,
		S_TRACK = 4'b0100,
		S_CONV = 4'b1000
	} acc_fsm_t;
	// Whole controller state
	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic [31:0] mode;
		logic [31:0] emr;
		logic [31:0] seqr;
		logic [31:0] cwr;
		logic [31:0] ier;
		logic [7:0] chsr;
		logic [7:0][9:0] cdr;
		logic [9:0] ldata;
		logic [2:0] lchan;
		logic [7:0] eoc;
		logic [7:0] channel_overrun_flag;
		logic data_ready_flag;
		logic general_overrun_flag;
		logic compare_event_flag;
		logic [1:0] filt;
		logic [8:0] div_cnt;
		logic tick;
		logic [7:0] tmr;
		logic [2:0] slot;
		logic [2:0] cur_ch;
		logic cell_start;
		logic pwr;
		logic stby;
		logic dma;
		logic irq;
		logic [3:0] sync1;
		logic [3:0] sync2;
		logic trg_prev;
		acc_fsm_t fsm;
	} acc_state_t;
endpackage

/* tb/acc_adc_ctrl_checker.sv */
/*
 * Port checker for the conversion controller: bus answers, cell start
 * pulses, power lines, DMA pulses. Assumes one clock and a sync reset.
 */
`timescale 1ns/10ps
module acc_adc_ctrl_checker (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_ack_out,
	input wire logic cell_done_in,
	input wire logic cell_start_out,
	input wire logic cell_power_out,
	input wire logic cell_standby_out,
	input wire logic dma_request_out,
	input wire logic irq_out
);
	// ****************************************
	// Assertions, all on the one clock
	// ****************************************
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_n_in);
	ack_answer_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
		else $error("ack missing one cycle after request");
	ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
		else $error("ack without request");
	dma_pulse_a: assert property (dma_request_out |=> !dma_request_out)
		else $error("dma request held");
	dma_cause_a: assert property (dma_request_out |-> $past(cell_done_in) || $past(cell_done_in, 2))
		else $error("dma request without conversion");
	start_pulse_a: assert property (cell_start_out |=> !cell_start_out)
		else $error("start held");
	start_power_a: assert property (cell_start_out |-> cell_power_out)
		else $error("start while cell powered down");
	standby_excl_a: assert property (cell_standby_out |-> !cell_power_out)
		else $error("standby while fully powered");
	// Reset itself is the antecedent here, so no disable
	reset_quiet_a: assert property (disable iff (1'b0) !rst_n_in |=> !wb_ack_out
		&& !dma_request_out && !cell_start_out && !irq_out && cell_power_out)
		else $error("outputs not quiet in reset");
	dma_c: cover property (dma_request_out);
	start_c: cover property (cell_start_out);
	standby_c: cover property (cell_standby_out);
endmodule // acc_adc_ctrl_checker
bind acc_adc_ctrl acc_adc_ctrl_checker u_chk (.ref_clk_in, .rst_n_in, .wb_cyc_in, .wb_stb_in,
	.wb_ack_out, .cell_done_in, .cell_start_out, .cell_power_out, .cell_standby_out,
	.dma_request_out, .irq_out);

/* tb/acc_cell_model.sv */
/*
 * Behavioural analog cell: converts after a short or long latency.
 * Assumes start and channel come on the same clock as the controller.
 */
`timescale 1ns/10ps
module acc_cell_model (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic start_in,
	input wire logic [2:0] chan_in,
	input wire logic slow_in,
	output logic done_out,
	output logic [9:0] data_out
);
	logic [3:0] cnt; // Cycles left in conversion
	logic [2:0] ch; // Channel latched at start
	logic [9:0] last; // Last value driven
	initial begin
		done_out = 1'b0;
		data_out = 10'h000;
		last = 10'h000;
		cnt = 4'h0;
		ch = 3'h0;
	end
	// Outside the done cycle the data shows the inverse, never a stale copy
	always @(posedge clk_in) begin
		done_out <= 1'b0;
		data_out <= ~last;
		if (!rst_n_in) begin
			cnt <= 4'h0;
		end else if (start_in) begin
			ch <= chan_in;
			cnt <= slow_in ? 4'hC : 4'h3;
		end else if (cnt == 4'h1) begin
			done_out <= 1'b1;
			data_out <= {ch, 7'h2B};
			last <= {ch, 7'h2B};
			cnt <= 4'h0;
		end else if (cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
		end
	end
endmodule // acc_cell_model

/* tb/tb_acc_adc_ctrl.sv */
/*
 * Bench for the conversion controller: Wishbone tasks, cell model,
 * trigger pulses. Assumes the register map of acc_pkg and a 20 MHz clock.
 */
`timescale 1ns/10ps
module tb_acc_adc_ctrl;
	logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, pin = 0, slow = 0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0000_0000, q;
	logic [2:0] tmr = 3'h0;
	logic ack, start, pwr, stby, irq, done, tick, dma;
	logic [31:0] rdat;
	logic [2:0] ch;
	logic [9:0] cdata;
	logic [5:0] ch_log = 6'h00; // Channels of the last two starts
	int num_errors = 0, n_checks = 0, dn = 0, cyc_cnt = 0, tk = 0, dmc = 0;
	initial forever #25 clk = ~clk;
	acc_adc_ctrl u_dut (.ref_clk_in(clk), .rst_n_in(rst_n), .wb_cyc_in(cyc), .wb_stb_in(stb),
		.wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
		.wb_ack_out(ack), .timer_waveform_output_in(tmr), .external_trigger_pin_in(pin),
		.cell_done_in(done), .cell_data_in(cdata), .cell_start_out(start),
		.cell_channel_out(ch), .cell_power_out(pwr), .cell_standby_out(stby),
		.conversion_clock_tick_out(tick), .dma_request_out(dma), .irq_out(irq));
	acc_cell_model u_cell (.clk_in(clk), .rst_n_in(rst_n), .start_in(start), .chan_in(ch),
		.slow_in(slow), .done_out(done), .data_out(cdata));
	// Counts conversions, logs channels, cuts a hang short
	always @(posedge clk) begin
		cyc_cnt <= cyc_cnt + 1;
		if (done) dn <= dn + 1;
		if (tick) tk <= tk + 1;
		if (dma) dmc <= dmc + 1;
		if (start) ch_log <= {ch_log[2:0], ch};
		if (cyc_cnt == 30000) begin
			num_errors++;
			stop_test();
		end
	end
	task stop_test();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One classic cycle, held until ack is sampled
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1;
		stb <= 1;
		we <= w;
		sel <= 4'hF;
		adr <= a;
		wdat <= d;
		@(posedge clk);
		while (ack !== 1'b1) @(posedge clk);
		q = rdat;
		cyc <= 0;
		stb <= 0;
		we <= 0;
		sel <= 4'h0;
	endtask
	// Conversion clock pulses over a window, once the divider has settled
	task ticks(input logic [31:0] md, input int n, input logic [31:0] e, input string nm);
		int k0;
		wb(1'b1, acc_pkg::OFS_MODE, md);
		repeat (20) @(posedge clk);
		k0 = tk;
		repeat (n) @(posedge clk);
		chk(nm, 32'(tk - k0), e);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		wb(1'b0, a, 32'h0000_0000);
		chk(nm, q, e);
	endtask
	task wait_done(input int k);
		int t;
		int tgt;
		tgt = dn + k;
		t = 0;
		while (dn < tgt && t < 3000) begin
			@(posedge clk);
			t++;
		end
		repeat (4) @(posedge clk);
	endtask
	// Pulses are spaced far beyond one sequence
	task pulse(input int k);
		@(posedge clk);
		if (k == 3) pin <= 1;
		else tmr[k] <= 1;
		repeat (4) @(posedge clk);
		pin <= 0;
		tmr <= 3'h0;
		repeat (30) @(posedge clk);
	endtask
	initial begin
		int m;
		int k;
		repeat (5) @(posedge clk);
		rst_n <= 1;
		rd(acc_pkg::OFS_MODE, acc_pkg::MODE_RST, "mode");
		rd(acc_pkg::OFS_SEQ_ORDER, acc_pkg::SEQ_RST, "seq");
		wb(1, acc_pkg::OFS_EXT_MODE, 32'h0100_1201);
		wb(1, acc_pkg::OFS_CMP_WINDOW, 32'h0000_0000);
		wb(1, acc_pkg::OFS_CH_ENABLE, 32'h0000_000A);
		rd(acc_pkg::OFS_CH_STATUS, 32'h0000_000A, "chsr");
		wb(1, acc_pkg::OFS_INT_ENABLE, 32'h0100_0000);
		wb(1, acc_pkg::OFS_CONTROL, 32'h0000_0002);
		wait_done(2);
		chk("irq", {31'h0, irq}, 32'h1);
		chk("dma", 32'(dmc), 32'h0000_0001);
		rd(acc_pkg::OFS_INT_STATUS, 32'h0700_000A, "isr");
		rd(acc_pkg::OFS_INT_STATUS, 32'h0100_000A, "isr2");
		rd(acc_pkg::OFS_LAST_RESULT, 32'h0000_31AB, "last");
		rd(acc_pkg::OFS_CH_RESULT + 8'h04, 32'h0000_00AB, "cdr1");
		chk("irq", {31'h0, irq}, 32'h0);
		rd(acc_pkg::OFS_INT_STATUS, 32'h0000_0008, "isr3");
		wb(1, acc_pkg::OFS_CONTROL, 32'h0000_0002);
		wait_done(2);
		rd(acc_pkg::OFS_OVERRUN, 32'h0000_0008, "ovr");
		rd(acc_pkg::OFS_OVERRUN, 32'h0000_0000, "ovr2");
		rd(acc_pkg::OFS_INT_STATUS, 32'h0700_000A, "isr4");
		// High threshold only matches once scaled down for low resolution
		wb(1, acc_pkg::OFS_CMP_WINDOW, 32'h00A0_0000);
		slow <= 1;
		wb(1, acc_pkg::OFS_MODE, 32'h0000_0010);
		wb(1, acc_pkg::OFS_CONTROL, 32'h0000_0002);
		wait_done(2);
		rd(acc_pkg::OFS_INT_STATUS, 32'h0700_000A, "isr5");
		rd(acc_pkg::OFS_CH_RESULT + 8'h04, 32'h0000_002A, "low");
		rd(acc_pkg::OFS_LAST_RESULT, 32'h0000_306A, "lowlast");
		slow <= 0;
		wb(1, acc_pkg::OFS_CH_DISABLE, 32'h0000_0008);
		rd(acc_pkg::OFS_CH_STATUS, 32'h0000_0002, "chsr2");
		// Every source code: a foreign edge is ignored, the chosen one converts
		for (m = 0; m < 4; m++) begin
			wb(1, acc_pkg::OFS_MODE, 32'h1 | (m << 1));
			k = dn;
			pulse((m + 1) % 4);
			chk("stray", 32'(dn), 32'(k));
			pulse(m);
			wait_done(1);
			chk("trig", 32'(dn), 32'(k + 1));
		end
		wb(1, acc_pkg::OFS_MODE, 32'h0000_0006);
		k = dn;
		pulse(3);
		chk("gated", 32'(dn), 32'(k));
		wb(1, acc_pkg::OFS_SEQ_ORDER, 32'h0000_0055);
		wb(1, acc_pkg::OFS_CH_ENABLE, 32'h0000_0001);
		wb(1, acc_pkg::OFS_MODE, 32'h8000_0000);
		wb(1, acc_pkg::OFS_CONTROL, 32'h0000_0002);
		wait_done(2);
		chk("user_sequence_enable", {26'h0, ch_log}, 32'h0000_002D);
		wb(1, acc_pkg::OFS_MODE, 32'h0002_0020);
		repeat (5) @(posedge clk);
		chk("sleep", {31'h0, pwr}, 32'h0);
		wb(1, acc_pkg::OFS_CONTROL, 32'h0000_0002);
		k = dn;
		repeat (20) @(posedge clk);
		chk("startup", 32'(dn), 32'(k));
		wait_done(2);
		chk("woke", 32'(dn), 32'(k + 2));
		chk("resleep", {31'h0, pwr}, 32'h0);
		wb(1, acc_pkg::OFS_MODE, 32'h0000_0060);
		repeat (5) @(posedge clk);
		chk("standby", {31'h0, stby}, 32'h1);
		ticks(32'h0000_0080, 60, 32'h0000_003C, "undiv");
		ticks(32'h0010_0000, 60, 32'h0000_0014, "divide_by_three_select");
		ticks(32'h0000_0400, 60, 32'h0000_0006, "div10");
		ticks(32'h0000_FF00, 1024, 32'h0000_0002, "div512");
		stop_test();
	end
endmodule // tb_acc_adc_ctrl
